/* File: logic/dmbs_bank_select.sv */
// Contract
// - all eight bits of the bank select register are real storage.
// - every special function register is reached by ordinary data memory reads and writes.
// - addresses 10h to 17h are steered to the selected peripheral bank, and 20h to ffh to the selected ram bank.
// - the low nibble of the bank select register numbers the active peripheral bank.
// - the high nibble of the bank select register numbers the active ram bank.
// - a dedicated instruction loads the peripheral bank nibble.
// - a dedicated instruction loads the ram bank nibble.
// - a read through an unimplemented bank returns all zeros.
// - a write to an unimplemented bank stores nothing yet the alu flags still update.
`timescale 1ns/1ns
module dmbs_bank_select #(
  parameter logic [15:0] PERIPH_IMPL = dmbs_pkg::DMBS_PERIPH_IMPL_DEF,
  parameter logic [15:0] GPR_IMPL = dmbs_pkg::DMBS_GPR_IMPL_DEF
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // core data memory access
  input wire logic [7:0] addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic alu_flags_upd_o,
  // bank load instructions
  input wire logic load_peripheral_bank_literal_i,
  input wire logic load_ram_bank_literal_i,
  input wire logic [3:0] bank_lit_i,
  // memory and register fabric
  output dmbs_pkg::dmbs_route_t tgt_route_o,
  output logic tgt_re_o,
  output logic tgt_we_o,
  output logic [7:0] tgt_wdata_o,
  input wire logic [7:0] tgt_rdata_i,
  // state
  output logic [7:0] bank_select_register_o
);

  logic [7:0] sel_q;
  logic [7:0] sel_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic flags_q;
  dmbs_pkg::dmbs_route_t route;

  dmbs_bank_decode #(
    .PERIPH_IMPL(PERIPH_IMPL),
    .GPR_IMPL(GPR_IMPL)
  ) u_decode (
    .addr_i(addr_i),
    .bank_sel_i(sel_q),
    .route_o(route)
  );

  wire logic hit_sel = (route.tgt == dmbs_pkg::DMBS_TGT_SEL);
  wire logic sel_wr = wr_i && hit_sel;
  wire logic [3:0] new_p = load_peripheral_bank_literal_i ? bank_lit_i : dmbs_pkg::dmbs_pbank(sel_q);
  wire logic [3:0] new_r = load_ram_bank_literal_i ? bank_lit_i : dmbs_pkg::dmbs_rbank(sel_q);
  wire logic lit_any = load_peripheral_bank_literal_i || load_ram_bank_literal_i;

  // a nibble load leaves the other nibble alone; it outranks a same-cycle data write
  assign sel_d = lit_any ? {new_r, new_p} : (sel_wr ? wdata_i : sel_q);

  // fabric strobes; writes into a missing bank go nowhere
  assign tgt_route_o = route;
  assign tgt_re_o = rd_i && !hit_sel && route.impl;
  assign tgt_we_o = wr_i && !hit_sel && route.impl;
  assign tgt_wdata_o = wdata_i;

  // reads of missing banks are forced to zero, never to the fabric's idle value
  assign rdata_d = hit_sel ? sel_q : (route.impl ? tgt_rdata_i : 8'h00);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sel_q <= dmbs_pkg::DMBS_SEL_RST;
    end else begin
      sel_q <= sel_d;
    end
  end

  // read data holds until the next read, so a slow core can still take it
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else if (rd_i) begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rd_i;
    end
  end

  // flags pulse for every write, dropped ones included
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      flags_q <= 1'b0;
    end else begin
      flags_q <= wr_i;
    end
  end

  assign rdata_o = rdata_q;
  assign rvalid_o = rvalid_q;
  assign alu_flags_upd_o = flags_q;
  assign bank_select_register_o = sel_q;

  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // previous bank select, for the keep-the-other-nibble checks
  logic [7:0] sel_p;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sel_p <= 8'h00;
    end else begin
      sel_p <= sel_q;
    end
  end

  a_full_byte_write: assert property (
    (wr_i && addr_i == dmbs_pkg::DMBS_SEL_ADDR && !lit_any) |=> (sel_q == $past(wdata_i)))
    else $error("bank select did not take the whole byte");

  a_fixed_reach: assert property (
    (wr_i && route.tgt == dmbs_pkg::DMBS_TGT_FIXED) |-> (tgt_we_o && tgt_route_o.addr == addr_i))
    else $error("unbanked register write not passed to fabric");

  a_window_steer: assert property (
    (addr_i >= dmbs_pkg::DMBS_WIN_LO && addr_i <= dmbs_pkg::DMBS_WIN_HI)
      |-> (tgt_route_o.tgt == dmbs_pkg::DMBS_TGT_PERIPH && tgt_route_o.bank == sel_q[3:0]))
    else $error("window access not steered to peripheral bank");

  a_low_nibble_bank: assert property (
    (tgt_route_o.tgt == dmbs_pkg::DMBS_TGT_PERIPH) |-> (tgt_route_o.impl == PERIPH_IMPL[sel_q[3:0]]))
    else $error("peripheral bank presence wrong");

  a_high_nibble_bank: assert property (
    (addr_i >= dmbs_pkg::DMBS_GPR_LO) |-> (tgt_route_o.tgt == dmbs_pkg::DMBS_TGT_GPR
      && tgt_route_o.bank == sel_q[7:4]))
    else $error("ram bank not taken from high nibble");

  a_load_pbank: assert property (
    (load_peripheral_bank_literal_i && !load_ram_bank_literal_i)
      |=> (sel_q[3:0] == $past(bank_lit_i) && sel_q[7:4] == sel_p[7:4]))
    else $error("peripheral bank load wrong");

  a_load_rbank: assert property (
    (load_ram_bank_literal_i && !load_peripheral_bank_literal_i)
      |=> (sel_q[7:4] == $past(bank_lit_i) && sel_q[3:0] == sel_p[3:0]))
    else $error("ram bank load wrong");

  a_missing_reads_zero: assert property (
    (rd_i && !route.impl) |=> (rvalid_o && rdata_o == 8'h00))
    else $error("read of missing bank not zero");

  a_missing_write_drop: assert property (
    (wr_i && !route.impl) |-> !tgt_we_o ##1 alu_flags_upd_o)
    else $error("missing bank write stored or flags not updated");

  a_fixed_decode: assert property (
    (addr_i < dmbs_pkg::DMBS_WIN_LO && addr_i != dmbs_pkg::DMBS_SEL_ADDR)
      |-> (tgt_route_o.tgt == dmbs_pkg::DMBS_TGT_FIXED && tgt_route_o.bank == 4'h0 && tgt_route_o.impl))
    else $error("fixed address decode depends on bank select");

  a_missing_read_quiet: assert property (
    (rd_i && !route.impl)
      |-> !tgt_re_o)
    else $error("read of missing bank reached the fabric");

  a_flags_every_write: assert property (
    wr_i
      |=> alu_flags_upd_o)
    else $error("alu flags not updated after a write");

  a_both_nibbles: assert property (
    (load_peripheral_bank_literal_i && load_ram_bank_literal_i)
      |=> (sel_q == {2{$past(bank_lit_i)}}))
    else $error("joint nibble load wrong");

  a_sel_read_back: assert property (
    (rd_i && addr_i == dmbs_pkg::DMBS_SEL_ADDR)
      |=> (rdata_o == sel_p))
    else $error("bank select read back wrong");

  a_ram_bank_present: assert property (
    (route.tgt == dmbs_pkg::DMBS_TGT_GPR)
      |-> (route.impl == GPR_IMPL[sel_q[7:4]]))
    else $error("ram bank presence wrong");

  a_read_valid: assert property (
    rd_i
      |=> rvalid_o)
    else $error("read not answered next cycle");

  a_write_pass: assert property (
    (wr_i && route.impl && !hit_sel)
      |-> (tgt_we_o && tgt_wdata_o == wdata_i))
    else $error("write not passed to fabric");

  a_rdata_hold: assert property (
    !rd_i
      |=> $stable(rdata_o))
    else $error("read data moved without a read");

  // main scenarios
  c_window_read: cover property (rd_i && route.tgt == dmbs_pkg::DMBS_TGT_PERIPH && route.impl ##1 rvalid_o);
  c_missing_write: cover property (wr_i && !route.impl);
  c_bank_switch: cover property (load_peripheral_bank_literal_i ##1 rd_i && route.tgt == dmbs_pkg::DMBS_TGT_PERIPH);
  c_ram_switch: cover property (load_ram_bank_literal_i ##1 wr_i && route.tgt == dmbs_pkg::DMBS_TGT_GPR);
  c_both_nibbles: cover property (load_peripheral_bank_literal_i && load_ram_bank_literal_i);

endmodule

/* File: logic/dmbs_pkg.sv */
package dmbs_pkg;

  // core data path widths
  localparam int unsigned DMBS_ADDR_W = 8;
  localparam int unsigned DMBS_DATA_W = 8;
  localparam int unsigned DMBS_NIB_W = 4;

  // data memory map
  localparam logic [7:0] DMBS_SEL_ADDR = 8'h0f;
  localparam logic [7:0] DMBS_WIN_LO = 8'h10;
  localparam logic [7:0] DMBS_WIN_HI = 8'h17;
  localparam logic [7:0] DMBS_GPR_LO = 8'h20;
  localparam logic [7:0] DMBS_GPR_HI = 8'hff;

  // bank select register layout and reset value
  localparam int unsigned DMBS_PBANK_LSB = 0;
  localparam int unsigned DMBS_RBANK_LSB = 4;
  localparam logic [7:0] DMBS_SEL_RST = 8'h00;

  // implemented banks, one bit per bank number
  localparam logic [15:0] DMBS_PERIPH_IMPL_DEF = 16'h003f;
  localparam logic [15:0] DMBS_GPR_IMPL_DEF = 16'h000f;
  localparam logic [3:0] DMBS_RSVD_PBANK = 4'hf;

  typedef enum logic [1:0] {
    DMBS_TGT_FIXED,
    DMBS_TGT_PERIPH,
    DMBS_TGT_GPR,
    DMBS_TGT_SEL
  } dmbs_tgt_t;

  typedef struct packed {
    dmbs_tgt_t tgt;
    logic [3:0] bank;
    logic [7:0] addr;
    logic impl;
  } dmbs_route_t;

  function automatic logic [3:0] dmbs_pbank(input logic [7:0] sel);
    return sel[DMBS_PBANK_LSB +: 4];
  endfunction

  function automatic logic [3:0] dmbs_rbank(input logic [7:0] sel);
    return sel[DMBS_RBANK_LSB +: 4];
  endfunction

  function automatic logic dmbs_in(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

endpackage

/* File: logic/dmbs_bank_decode.sv */
`timescale 1ns/1ns
module dmbs_bank_decode #(
  parameter logic [15:0] PERIPH_IMPL = dmbs_pkg::DMBS_PERIPH_IMPL_DEF,
  parameter logic [15:0] GPR_IMPL = dmbs_pkg::DMBS_GPR_IMPL_DEF
) (
  // access
  input wire logic [7:0] addr_i,
  input wire logic [7:0] bank_sel_i,
  // routing
  output dmbs_pkg::dmbs_route_t route_o
);

  wire logic in_win = dmbs_pkg::dmbs_in(addr_i, dmbs_pkg::DMBS_WIN_LO, dmbs_pkg::DMBS_WIN_HI);
  wire logic in_gpr = dmbs_pkg::dmbs_in(addr_i, dmbs_pkg::DMBS_GPR_LO, dmbs_pkg::DMBS_GPR_HI);
  wire logic is_sel = (addr_i == dmbs_pkg::DMBS_SEL_ADDR);
  wire logic [3:0] pbank = dmbs_pkg::dmbs_pbank(bank_sel_i);
  wire logic [3:0] rbank = dmbs_pkg::dmbs_rbank(bank_sel_i);

  // banked window and gpr use the nibbles, all else ignores the bank select
  assign route_o.tgt = in_win ? dmbs_pkg::DMBS_TGT_PERIPH :
                       in_gpr ? dmbs_pkg::DMBS_TGT_GPR :
                       is_sel ? dmbs_pkg::DMBS_TGT_SEL : dmbs_pkg::DMBS_TGT_FIXED;
  assign route_o.bank = in_win ? pbank : (in_gpr ? rbank : 4'h0);
  assign route_o.addr = addr_i;
  assign route_o.impl = in_win ? PERIPH_IMPL[pbank] : (in_gpr ? GPR_IMPL[rbank] : 1'b1);

endmodule

/* File: tb/dmbs_fabric_model.sv */
`timescale 1ns/1ns
module dmbs_fabric_model (
  // clock
  input wire logic clk_sys_i,
  // fabric side of the bank decoder
  input wire dmbs_pkg::dmbs_route_t route_i,
  input wire logic re_i,
  input wire logic we_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem_q [0:8191];
  logic [3:0] bank;
  logic [12:0] idx;
  // fixed places ignore the bank field, so a stray bank cannot alias them
  assign bank = (route_i.tgt == dmbs_pkg::DMBS_TGT_FIXED) ? 4'h0 : route_i.bank;
  assign idx = {route_i.tgt[0], bank, route_i.addr};
  // unselected reads show the inverse so stale data cannot pass
  assign rdata_o = re_i ? mem_q[idx] : ~mem_q[idx];
  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem_q[idx] <= wdata_i;
    end
  end
endmodule

/* File: tb/dmbs_bank_select_tb.sv */
`timescale 1ns/1ns
module dmbs_bank_select_tb;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic rd_i = 1'b0;
  logic wr_i = 1'b0;
  logic [7:0] wdata_i = 8'h00;
  logic ldp = 1'b0;
  logic ldr = 1'b0;
  logic [3:0] bank_lit_i = 4'h0;
  logic [7:0] rdata_o, tgt_wdata_o, tgt_rdata_i, bank_sel, v;
  logic rvalid_o, alu_flags_upd_o, tgt_re_o, tgt_we_o;
  dmbs_pkg::dmbs_route_t route;
  int n_errors = 0;
  int n_compared = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  dmbs_bank_select u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i), .rd_i(rd_i), .wr_i(wr_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .alu_flags_upd_o(alu_flags_upd_o),
    .load_peripheral_bank_literal_i(ldp), .load_ram_bank_literal_i(ldr), .bank_lit_i(bank_lit_i),
    .tgt_route_o(route), .tgt_re_o(tgt_re_o), .tgt_we_o(tgt_we_o), .tgt_wdata_o(tgt_wdata_o),
    .tgt_rdata_i(tgt_rdata_i), .bank_select_register_o(bank_sel));
  dmbs_fabric_model u_fab (.clk_sys_i(clk_sys_i), .route_i(route), .re_i(tgt_re_o), .we_i(tgt_we_o),
    .wdata_i(tgt_wdata_o), .rdata_o(tgt_rdata_i));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // each call sets every strobe once; a strobe stays up until the next call,
  // so back to back requests never toggle one signal twice in a time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i = a;
    wdata_i = d;
    rd_i = 1'b0;
    ldp = 1'b0;
    ldr = 1'b0;
    wr_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    chk({7'h0, alu_flags_upd_o}, 8'h01);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr_i = a;
    wr_i = 1'b0;
    ldp = 1'b0;
    ldr = 1'b0;
    rd_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    chk({7'h0, rvalid_o}, 8'h01);
    d = rdata_o;
  endtask
  task automatic ld(input logic p, input logic r, input logic [3:0] lit);
    rd_i = 1'b0;
    wr_i = 1'b0;
    ldp = p;
    ldr = r;
    bank_lit_i = lit;
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // whole run is under a hundred cycles
  initial begin
    #100000;
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge clk_sys_i);
    #1 rst_i = 1'b0;
    chk(bank_sel, 8'h00);
    wr(8'h0f, 8'h5a);
    chk(bank_sel, 8'h5a);
    rd(8'h0f, v);
    chk(v, 8'h5a);
    ld(1'b1, 1'b0, 4'h2);
    ld(1'b0, 1'b1, 4'h3);
    chk(bank_sel, 8'h32);
    $display("test register done");
    wr(8'h10, 8'h22);
    chk({6'h0, route.tgt}, {6'h0, dmbs_pkg::DMBS_TGT_PERIPH});
    chk({4'h0, route.bank}, 8'h02);
    ld(1'b1, 1'b0, 4'h1);
    wr(8'h10, 8'h11);
    rd(8'h10, v);
    chk(v, 8'h11);
    ld(1'b1, 1'b0, 4'h2);
    rd(8'h10, v);
    chk(v, 8'h22);
    wr(8'h20, 8'h33);
    ld(1'b0, 1'b1, 4'h0);
    wr(8'h20, 8'h44);
    rd(8'h20, v);
    chk(v, 8'h44);
    ld(1'b0, 1'b1, 4'h3);
    rd(8'h20, v);
    chk(v, 8'h33);
    $display("test banks done");
    ld(1'b1, 1'b0, 4'hd);
    wr(8'h10, 8'hff);
    rd(8'h10, v);
    chk(v, 8'h00);
    ld(1'b1, 1'b0, 4'h2);
    rd(8'h10, v);
    chk(v, 8'h22);
    // bank 15 window contents are never compared, only fixed places
    wr(8'h05, 8'h6c);
    ld(1'b1, 1'b1, dmbs_pkg::DMBS_RSVD_PBANK);
    rd(8'h05, v);
    chk(v, 8'h6c);
    $display("test unimplemented and fixed done");
    stop_test();
  end
endmodule
